// File: rtl/hbra_host_port.sv
// Host bus request/grant arbitration and asynchronous host access to the I/O register file.
// Assumes host pins are asynchronous to clk; core-side signals are on clk.
`timescale 1ns/1ns
module hbra_host_port
    import hbra_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       ce,
    input  wire logic                       ready_active_drive,
    input  wire logic                       host_bus_request_n,
    input  wire logic                       chip_sel_n,
    input  wire logic                       rd_n,
    input  wire logic                       wr_n,
    input  wire logic [hbra_pkg::ADDR_W-1:0] host_addr,
    input  wire logic [hbra_pkg::DATA_W-1:0] host_data_in,
    input  wire logic                       core_priority_access_n,
    input  wire logic                       peer_bus_request_in_n,
    input  wire logic                       core_bus_want,
    output logic                            host_bus_grant_n,
    output logic                            host_ready_ack_o,
    output logic                            host_ready_ack_oe,
    output logic [hbra_pkg::DATA_W-1:0]     host_data_out,
    output logic                            host_data_oe,
    output logic                            peer_bus_request_n,
    output logic                            mem_if_release,
    output logic                            iop_wr_pulse,
    output logic [hbra_pkg::REG_IDX_W-1:0]  iop_wr_idx,
    output logic [hbra_pkg::DATA_W-1:0]     iop_wr_data
);
    import hbra_pkg::*;

    localparam int PIN_W = 5;

    logic [PIN_W-1:0]            pins_q;
    logic [ADDR_W+DATA_W-1:0]    bus_q;
    logic                        s_req_n;
    logic                        s_cs_n;
    logic                        s_rd_n;
    logic                        s_wr_n;
    logic                        s_cpa_n;
    logic [ADDR_W-1:0]           s_addr;
    logic [DATA_W-1:0]           s_wdata;

    // Strobes, selects and the address/data buses all pass the same filtered pipeline,
    // so a strobe edge and the bus value seen with it stay aligned.
    hbra_sync3 #(.W(PIN_W), .INIT(5'h1f)) u_sync_pins (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .d     ({host_bus_request_n, chip_sel_n, rd_n, wr_n, core_priority_access_n}),
        .q     (pins_q)
    );

    hbra_sync3 #(.W(ADDR_W+DATA_W), .INIT('0)) u_sync_bus (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .d     ({host_addr, host_data_in}),
        .q     (bus_q)
    );

    assign s_req_n = pins_q[4];
    assign s_cs_n  = pins_q[3];
    assign s_rd_n  = pins_q[2];
    assign s_wr_n  = pins_q[1];
    assign s_cpa_n = pins_q[0];
    assign s_addr  = bus_q[ADDR_W+DATA_W-1:DATA_W];
    assign s_wdata = bus_q[DATA_W-1:0];

    // Priority is taken on the synchronised assertion but dropped at once on the raw pin.
    logic cpa_hold;
    assign cpa_hold = !s_cpa_n && !core_priority_access_n;

    // Grant state
    hbra_gnt_t gs_r;
    hbra_gnt_t gs_nxt;
    logic      grant_n_r;
    logic      grant_n_nxt;
    logic      release_r;
    logic      release_nxt;
    logic      peer_req_n_r;
    logic      peer_req_n_nxt;

    always_comb
    begin
        gs_nxt         = gs_r;
        grant_n_nxt    = grant_n_r;
        release_nxt    = release_r;
        peer_req_n_nxt = !(core_bus_want && gs_r == GS_OWN);
        unique case (gs_r)
            GS_OWN:
            begin
                if (!s_req_n && !cpa_hold)
                begin
                    gs_nxt      = GS_RELEASE;
                    release_nxt = 1'b1;
                end
            end
            GS_RELEASE:
            begin
                if (s_req_n)
                begin
                    gs_nxt = GS_RECLAIM;
                end
                else
                begin
                    gs_nxt      = GS_GRANTED;
                    grant_n_nxt = 1'b0;
                end
            end
            GS_GRANTED:
            begin
                if (s_req_n)
                begin
                    gs_nxt      = GS_RECLAIM;
                    grant_n_nxt = 1'b1;
                end
            end
            GS_RECLAIM:
            begin
                gs_nxt      = GS_OWN;
                release_nxt = 1'b0;
            end
            default:
            begin
                gs_nxt      = GS_RECLAIM;
                grant_n_nxt = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gs_r         <= GS_OWN;
            grant_n_r    <= 1'b1;
            release_r    <= 1'b0;
            peer_req_n_r <= 1'b1;
        end
        else if (ce)
        begin
            gs_r         <= gs_nxt;
            grant_n_r    <= grant_n_nxt;
            release_r    <= release_nxt;
            peer_req_n_r <= peer_req_n_nxt;
        end
    end

    // Access state and register file
    logic                 granted;
    logic                 host_sel;
    logic                 non_mms;
    hbra_acc_t            as_r;
    hbra_acc_t            as_nxt;
    logic [CNT_W-1:0]     cnt_r;
    logic [CNT_W-1:0]     cnt_nxt;
    logic [DATA_W-1:0]    rdata_r;
    logic [DATA_W-1:0]    rdata_nxt;
    logic                 doe_r;
    logic                 doe_nxt;
    logic [ADDR_W-1:0]    waddr_r;
    logic [ADDR_W-1:0]    waddr_nxt;
    logic [DATA_W-1:0]    wdata_r;
    logic [DATA_W-1:0]    wdata_nxt;
    logic                 wpulse_r;
    logic                 wpulse_nxt;
    logic [DATA_W-1:0]    regs_r   [REG_NUM];
    logic [DATA_W-1:0]    regs_nxt [REG_NUM];

    assign granted  = !grant_n_r;
    assign host_sel = granted && !s_cs_n && !s_req_n;
    // Accesses inside multiprocessor space are not for this register file.
    assign non_mms  = s_addr[NMMS_BIT];

    always_comb
    begin
        as_nxt     = as_r;
        cnt_nxt    = cnt_r;
        rdata_nxt  = rdata_r;
        doe_nxt    = doe_r;
        waddr_nxt  = waddr_r;
        wdata_nxt  = wdata_r;
        wpulse_nxt = 1'b0;
        regs_nxt   = regs_r;
        if (!host_sel)
        begin
            as_nxt  = AS_IDLE;
            doe_nxt = 1'b0;
        end
        else
        begin
            unique case (as_r)
                AS_IDLE:
                begin
                    if (!s_rd_n)
                    begin
                        as_nxt    = AS_RD_HOLD;
                        cnt_nxt   = RD_CYC;
                        // Data driven from the start of the ready-low window.
                        rdata_nxt = non_mms ? regs_r[s_addr[REG_IDX_W-1:0]] : REG_RESET;
                        doe_nxt   = 1'b1;
                    end
                    else if (!s_wr_n)
                    begin
                        as_nxt    = AS_WR_HOLD;
                        cnt_nxt   = WR_CYC;
                        waddr_nxt = s_addr;
                        wdata_nxt = s_wdata;
                    end
                end
                AS_RD_HOLD:
                begin
                    if (cnt_r <= CNT_ONE)
                    begin
                        as_nxt = AS_RD_DONE;
                    end
                    cnt_nxt = cnt_r - CNT_ONE;
                end
                AS_RD_DONE:
                begin
                    if (s_rd_n)
                    begin
                        as_nxt  = AS_IDLE;
                        doe_nxt = 1'b0;
                    end
                end
                AS_WR_HOLD, AS_WR_DONE:
                begin
                    if (as_r == AS_WR_HOLD)
                    begin
                        if (cnt_r <= CNT_ONE)
                        begin
                            as_nxt = AS_WR_DONE;
                        end
                        cnt_nxt = cnt_r - CNT_ONE;
                    end
                    if (!s_wr_n)
                    begin
                        // Closely spaced writes are paced by ready; the last bus value wins
                        waddr_nxt = s_addr;
                        wdata_nxt = s_wdata;
                    end
                    else if (as_r == AS_WR_DONE)
                    begin
                        // Rising strobe: commit the last captured address and data.
                        as_nxt = AS_IDLE;
                        if (waddr_r[NMMS_BIT])
                        begin
                            regs_nxt[waddr_r[REG_IDX_W-1:0]] = wdata_r;
                            wpulse_nxt = 1'b1;
                        end
                    end
                end
                default:
                begin
                    as_nxt  = AS_IDLE;
                    doe_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            as_r     <= AS_IDLE;
            cnt_r    <= '0;
            rdata_r  <= REG_RESET;
            doe_r    <= 1'b0;
            waddr_r  <= '0;
            wdata_r  <= REG_RESET;
            wpulse_r <= 1'b0;
            for (int i = 0; i < REG_NUM; i++)
            begin
                regs_r[i] <= REG_RESET;
            end
        end
        else if (ce)
        begin
            as_r     <= as_nxt;
            cnt_r    <= cnt_nxt;
            rdata_r  <= rdata_nxt;
            doe_r    <= doe_nxt;
            waddr_r  <= waddr_nxt;
            wdata_r  <= wdata_nxt;
            wpulse_r <= wpulse_nxt;
            regs_r   <= regs_nxt;
        end
    end

    // Ready pin
    logic sel_both;
    logic pull_low;
    assign sel_both = !s_cs_n && !s_req_n;
    assign pull_low = (sel_both && !granted) || as_r == AS_RD_HOLD || as_r == AS_WR_HOLD;

    always_comb
    begin
        if (ready_active_drive)
        begin
            host_ready_ack_oe = sel_both;
            host_ready_ack_o  = !pull_low;
        end
        else
        begin
            host_ready_ack_oe = pull_low;
            host_ready_ack_o  = 1'b0;
        end
    end

    assign host_bus_grant_n   = grant_n_r;
    assign mem_if_release     = release_r;
    assign peer_bus_request_n = peer_req_n_r;
    assign host_data_out      = rdata_r;
    assign host_data_oe       = doe_r;
    assign iop_wr_pulse       = wpulse_r;
    assign iop_wr_idx         = waddr_r[REG_IDX_W-1:0];
    assign iop_wr_data        = wdata_r;

    // Checks
    property p_grant_needs_release;
        @(posedge clk) disable iff (!rst_n)
        !host_bus_grant_n |-> mem_if_release;
    endproperty
    a_grant_needs_release: assert property (p_grant_needs_release)
        else $error("grant low while memory interface driven");

    property p_grant_after_req;
        @(posedge clk) disable iff (!rst_n)
        (ce && gs_r == GS_OWN && !s_req_n && !cpa_hold) |=> ##1 (ce ? !host_bus_grant_n : 1'b1);
    endproperty
    a_grant_after_req: assert property (p_grant_after_req)
        else $error("grant not returned two cycles after sampled request");

    property p_cpa_blocks;
        @(posedge clk) disable iff (!rst_n)
        (ce && gs_r == GS_OWN && cpa_hold) |=> gs_r == GS_OWN;
    endproperty
    a_cpa_blocks: assert property (p_cpa_blocks)
        else $error("grant path taken while priority held");

    property p_od_never_high;
        @(posedge clk) disable iff (!rst_n)
        (!ready_active_drive && host_ready_ack_oe) |-> !host_ready_ack_o;
    endproperty
    a_od_never_high: assert property (p_od_never_high)
        else $error("open-drain ready driven high");

    property p_ready_low_before_grant;
        @(posedge clk) disable iff (!rst_n)
        (sel_both && host_bus_grant_n) |-> host_ready_ack_oe && !host_ready_ack_o;
    endproperty
    a_ready_low_before_grant: assert property (p_ready_low_before_grant)
        else $error("ready not pulled low while awaiting grant");

    property p_ad_release;
        @(posedge clk) disable iff (!rst_n)
        (ready_active_drive && !sel_both) |-> !host_ready_ack_oe;
    endproperty
    a_ad_release: assert property (p_ad_release)
        else $error("active ready still driven after deselect");

    property p_read_data_before_release;
        @(posedge clk) disable iff (!rst_n)
        (ce && as_r == AS_RD_HOLD) |-> host_data_oe ##1 $stable(host_data_out);
    endproperty
    a_read_data_before_release: assert property (p_read_data_before_release)
        else $error("read data not driven while ready low");

    property p_data_off_after_rd;
        @(posedge clk) disable iff (!rst_n)
        (ce && as_r == AS_RD_DONE && s_rd_n) |=> !host_data_oe;
    endproperty
    a_data_off_after_rd: assert property (p_data_off_after_rd)
        else $error("data bus still driven after read strobe rose");

    property p_wr_pulse_min;
        @(posedge clk) disable iff (!rst_n)
        (ce && as_r == AS_IDLE && host_sel && s_rd_n && !s_wr_n) |=> as_r == AS_WR_HOLD;
    endproperty
    a_wr_pulse_min: assert property (p_wr_pulse_min)
        else $error("write did not hold ready low");

    property p_commit_on_rise;
        @(posedge clk) disable iff (!rst_n)
        iop_wr_pulse |-> regs_r[iop_wr_idx] == iop_wr_data && $past(as_r) == AS_WR_DONE;
    endproperty
    a_commit_on_rise: assert property (p_commit_on_rise)
        else $error("register write not committed from captured data");
endmodule

// File: rtl/hbra_pkg.sv
// Constants shared by the host bus port: pin widths, register file shape, timing counts, states.
// Assumes a single 50 MHz clock and active-low host pins.
package hbra_pkg;

    localparam int          ADDR_W      = 24;
    localparam int          DATA_W      = 32;
    localparam int          REG_IDX_W   = 3;
    localparam int          REG_NUM     = 8;
    localparam int          NMMS_BIT    = ADDR_W - 1;

    localparam int          CLK_PS      = 20000;
    localparam int          RD_PULSE_PS = 28000;
    localparam int          WR_PULSE_PS = 7750;
    localparam int          CNT_W       = 4;
    localparam logic [CNT_W-1:0] RD_CYC = CNT_W'((RD_PULSE_PS + CLK_PS - 1) / CLK_PS);
    localparam logic [CNT_W-1:0] WR_CYC = CNT_W'((WR_PULSE_PS + CLK_PS - 1) / CLK_PS);
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

    localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;

    typedef enum logic [3:0] {
        GS_OWN     = 4'b0001,
        GS_RELEASE = 4'b0010,
        GS_GRANTED = 4'b0100,
        GS_RECLAIM = 4'b1000
    } hbra_gnt_t;

    typedef enum logic [4:0] {
        AS_IDLE    = 5'b00001,
        AS_RD_HOLD = 5'b00010,
        AS_RD_DONE = 5'b00100,
        AS_WR_HOLD = 5'b01000,
        AS_WR_DONE = 5'b10000
    } hbra_acc_t;

endpackage

// File: rtl/hbra_sync3.sv
// Three-stage input synchroniser with agreement filter for pins from outside the clock domain.
// The output follows a change only once the second and third stages agree.
`timescale 1ns/1ns
module hbra_sync3 #(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    always_comb
    begin
        for (int i = 0; i < W; i++)
        begin
            q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q_r[i];
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_r <= INIT;
            s2_r <= INIT;
            s3_r <= INIT;
            q_r  <= INIT;
        end
        else if (ce)
        begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r  <= q_nxt;
        end
    end

    assign q = q_r;
endmodule

// File: bench/hbra_host_model.sv
// Behavioural host: asks for the bus, then runs handshaked register reads and writes.
// Assumes the ready level it sees already has the pull-up resolved by the bench.
`timescale 1ns/1ns
module hbra_host_model
    import hbra_pkg::*;
(
    input  wire logic                        clk,
    input  wire logic                        host_bus_grant_n,
    input  wire logic                        rdy,
    input  wire logic [hbra_pkg::DATA_W-1:0] dout,
    input  wire logic                        doe,
    output logic                             req_n,
    output logic                             cs_n,
    output logic                             rd_n,
    output logic                             wr_n,
    output logic [hbra_pkg::ADDR_W-1:0]      addr,
    output logic [hbra_pkg::DATA_W-1:0]      din
);
    logic [ADDR_W-1:0] a_r;
    logic              force_hi;
    logic              saw_low;
    logic              doe_seen;
    int                errs;
    int                wait_n;
    int                low_n;

    initial
    begin
        {req_n, cs_n, rd_n, wr_n} = 4'hf;
        a_r = '0;
        din = '0;
        force_hi = 1'b1;
        saw_low = 1'b0;
        doe_seen = 1'b0;
        errs = 0;
    end

    // Upper line forced high while granted and force_hi is set keeps accesses out of shared space
    assign addr = {a_r[ADDR_W-1] | (force_hi & ~host_bus_grant_n), a_r[ADDR_W-2:0]};

    task automatic wait_rdy(input logic lvl);
        low_n = 0;
        while (rdy !== lvl && low_n < 40)
        begin
            @(posedge clk);
            #1;
            low_n++;
        end
        if (low_n == 40)
            errs++;
    endtask

    task automatic request;
        @(posedge clk);
        #2;
        {cs_n, req_n} = 2'b00;
        saw_low = 1'b0;
        wait_n = 0;
        while (host_bus_grant_n !== 1'b0 && wait_n < 60)
        begin
            @(posedge clk);
            #1;
            if (rdy === 1'b0)
                saw_low = 1'b1;
            wait_n++;
        end
        if (wait_n == 60)
            errs++;
    endtask

    task automatic release_bus;
        @(posedge clk);
        #2;
        {cs_n, req_n} = 2'b11;
    endtask

    task automatic write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        #2;
        a_r = a;
        din = d;
        wr_n = 1'b0;
        wait_rdy(1'b0);
        wait_rdy(1'b1);
        #1;
        wr_n = 1'b1;
        repeat (6) @(posedge clk);
        #2;
        din = ~d;
    endtask

    task automatic read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        #2;
        a_r = a;
        rd_n = 1'b0;
        wait_rdy(1'b0);
        wait_rdy(1'b1);
        d = dout;
        doe_seen = doe;
        #1;
        rd_n = 1'b1;
        repeat (3) @(posedge clk);
        #2;
    endtask
endmodule

// File: bench/tb_host_bus_request_async_access.sv
// Self-checking bench for the host bus port: grant handover, ready styles, reads and writes.
// Assumes the host model drives every host pin; ready has a pull-up on the board.
`timescale 1ns/1ns
module tb_host_bus_request_async_access;
    import hbra_pkg::*;
    logic                 clk = 1'b0;
    logic                 rst_n = 1'b0;
    logic                 active = 1'b1;
    logic                 cpa_n = 1'b1;
    logic                 want = 1'b0;
    logic                 ce_in = 1'b1;
    logic                 req_n, cs_n, rd_n, wr_n, gnt_n, rdy_o, rdy_oe, doe, peer_n, rel, wp;
    wire                  rdy;
    logic [ADDR_W-1:0]    addr;
    logic [DATA_W-1:0]    din, dout, wdat, rdat;
    logic [REG_IDX_W-1:0] widx;
    int                   n_mismatch = 0;
    int                   check_count = 0;
    int                   cyc = 0;
    int                   n_wp = 0;

    always #10 clk = ~clk;
    assign rdy = rdy_oe ? rdy_o : 1'b1;

    hbra_host_port dut (.clk(clk), .rst_n(rst_n), .ce(ce_in), .ready_active_drive(active),
        .host_bus_request_n(req_n), .chip_sel_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .host_addr(addr), .host_data_in(din), .core_priority_access_n(cpa_n),
        .peer_bus_request_in_n(1'b1), .core_bus_want(want), .host_bus_grant_n(gnt_n),
        .host_ready_ack_o(rdy_o), .host_ready_ack_oe(rdy_oe), .host_data_out(dout),
        .host_data_oe(doe), .peer_bus_request_n(peer_n), .mem_if_release(rel),
        .iop_wr_pulse(wp), .iop_wr_idx(widx), .iop_wr_data(wdat));

    hbra_host_model host (.clk(clk), .host_bus_grant_n(gnt_n), .rdy(rdy), .dout(dout),
        .doe(doe), .req_n(req_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
        .din(din));

    task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results;
        if (n_mismatch == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            results;
        end
    end

    // Standing checks, sampled mid-cycle where outputs are settled
    always @(negedge clk)
    begin
        if (wp === 1'b1)
            n_wp++;
        if (gnt_n === 1'b0)
            check(32'(rel), 32'h1);
        if (rdy_oe === 1'b1 && active === 1'b0)
            check(32'(rdy_o), 32'h0);
    end

    task automatic do_reset(input logic mode);
        @(posedge clk);
        #2;
        rst_n = 1'b0;
        active = mode;
        repeat (5) @(posedge clk);
        check(32'({gnt_n, rel, peer_n, doe, wp, rdy_oe}), 32'h28);
        #2;
        rst_n = 1'b1;
    endtask

    task automatic wait_wp(input int target);
        int n;
        n = 0;
        while (n_wp < target && n < 12)
        begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic t_peer_and_priority;
        @(posedge clk);
        #2;
        want = 1'b1;
        cpa_n = 1'b0;
        repeat (6) @(negedge clk);
        check(32'(peer_n), 32'h0);
        fork
            host.request;
            begin
                repeat (20) @(posedge clk);
                #2;
                cpa_n = 1'b1;
            end
        join
        check(32'(host.wait_n > 20), 32'h1);
        check(32'(gnt_n), 32'h0);
        check(32'(host.saw_low), 32'h1);
        @(negedge clk);
        check(32'(peer_n), 32'h1);
        check(32'(rdy), 32'h1);
    endtask

    task automatic t_writes;
        int base;
        base = n_wp;
        host.write(24'h000003, 32'h1234_5678);
        check(32'(host.low_n >= int'(WR_CYC)), 32'h1);
        wait_wp(base + 1);
        check(32'(n_wp - base), 32'h1);
        check({29'h0, widx}, 32'h3);
        check(wdat, 32'h1234_5678);
        host.write(24'h000005, 32'ha5a5_0f0f);
        host.write(24'h000006, 32'h0bad_cafe);
        wait_wp(base + 3);
        check(32'(n_wp - base), 32'h3);
        check({29'h0, widx}, 32'h6);
        check(wdat, 32'h0bad_cafe);
        host.force_hi = 1'b0;
        host.write(24'h000007, 32'hffff_ffff);
        repeat (8) @(negedge clk);
        check(32'(n_wp - base), 32'h3);
    endtask

    task automatic t_reads;
        int n;
        host.read(24'h000005, rdat);
        check(rdat, 32'h0);
        host.force_hi = 1'b1;
        host.read(24'h000003, rdat);
        check(rdat, 32'h1234_5678);
        check(32'(host.doe_seen), 32'h1);
        check(32'(host.low_n >= int'(RD_CYC)), 32'h1);
        n = 0;
        while (doe !== 1'b0 && n < 8)
        begin
            @(negedge clk);
            n++;
        end
        check(32'(doe), 32'h0);
    endtask

    // Clock enable low must hold the request pipeline, so no grant appears meanwhile
    task automatic t_freeze;
        fork
            host.request;
            begin
                @(posedge clk);
                #2;
                ce_in = 1'b0;
                repeat (12) @(negedge clk);
                check(32'(gnt_n), 32'h1);
                @(posedge clk);
                #2;
                ce_in = 1'b1;
            end
        join
        check(32'(host.wait_n > 12), 32'h1);
    endtask

    task automatic t_release;
        host.release_bus;
        repeat (8) @(negedge clk);
        check(32'({gnt_n, rel, rdy_oe}), 32'h4);
        check(32'(peer_n), 32'h0);
    endtask

    initial
    begin
        do_reset(1'b1);
        t_peer_and_priority;
        t_writes;
        t_reads;
        t_release;
        // Second reset in mid-run switches to the open-drain ready style
        do_reset(1'b0);
        t_freeze;
        check(32'(host.saw_low), 32'h1);
        host.read(24'h000003, rdat);
        check(rdat, REG_RESET);
        t_release;
        check(32'(host.errs), 32'h0);
        results;
    end
endmodule
